// ### verilog/ris_i2c_regs.svh
// Constants of the serial register-access slave
`ifndef RIS_I2C_REGS_SVH
`define RIS_I2C_REGS_SVH

`define RIS_DEV_ADDR 7'h68
`define RIS_BYTE_BITS 4'h8
`define RIS_PTR_RST 8'h00
`define RIS_TIMEOUT_MS 35
`define RIS_CLK_PERIOD_NS 10
`define RIS_NS_PER_MS 1000000
`define RIS_TO_CNT_W 22

`endif

// ### verilog/ris_pkg.sv
// Types of the serial register-access slave
package ris_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ris_word_s;

  typedef enum logic [2:0] {
    RIS_IDLE,
    RIS_ADDR,
    RIS_ADDR_ACK,
    RIS_RX,
    RIS_RX_ACK,
    RIS_TX,
    RIS_TX_ACK,
    RIS_IGNORE
  } ris_state_e;

endpackage

// ### verilog/ris_i2c_slave.sv
// Serial register-access slave with link-side protocol and system-side ports
`timescale 1ns/1ps
`include "ris_i2c_regs.svh"

// ----------------------------------------
// Two-entry word buffer
// ----------------------------------------
module ris_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rptr_reg];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + AW'(1);
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------
// Top level
// ----------------------------------------
module ris_i2c_slave #(
  parameter int TIMEOUT_CYC = `RIS_TIMEOUT_MS * (`RIS_NS_PER_MS / `RIS_CLK_PERIOD_NS)
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output ris_pkg::ris_word_s wr_word_o,
  output logic rd_stb_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  output logic snap_o
);
  import ris_pkg::*;

  // ----------------------------------------
  // Link domain signals
  // ----------------------------------------
  logic lrst_s1_reg;
  logic lrst_n;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic fack_s1_reg, fack_s2_reg, fack_seen_reg;
  logic wack_s1_reg, wack_s2_reg;
  logic to_s1_reg, to_s2_reg, to_seen_reg;
  ris_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] fetch_addr_reg;
  logic [7:0] fetch_data_reg;
  logic fetch_req_reg;
  logic first_reg;
  logic oe_n_reg;
  logic snap_tgl_reg;
  logic wr_req_reg;
  ris_word_s wr_hold_reg;
  logic rise, fall, start_c, stop_c, timeout_c, wr_free;

  // ----------------------------------------
  // System domain signals
  // ----------------------------------------
  logic freq_s1_reg, freq_s2_reg, fack_reg;
  logic wreq_s1_reg, wreq_s2_reg, wack_reg;
  logic snp_s1_reg, snp_s2_reg, snp_seen_reg;
  logic rscl_s1_reg, rscl_s2_reg;
  logic to_tgl_reg;
  logic [`RIS_TO_CNT_W-1:0] to_cnt_reg;
  logic [7:0] rdata_reg;
  logic rd_stb_reg;
  logic [7:0] rd_addr_reg;
  logic snap_reg;
  logic fifo_in_ready;
  logic fifo_push;

  // ----------------------------------------
  // Link reset and synchronisers
  // ----------------------------------------
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lrst_s1_reg <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1_reg <= 1'b1;
      lrst_n <= lrst_s1_reg;
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      fack_s1_reg <= 1'b0;
      fack_s2_reg <= 1'b0;
      wack_s1_reg <= 1'b0;
      wack_s2_reg <= 1'b0;
      to_s1_reg <= 1'b0;
      to_s2_reg <= 1'b0;
    end else begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      fack_s1_reg <= fack_reg;
      fack_s2_reg <= fack_s1_reg;
      wack_s1_reg <= wack_reg;
      wack_s2_reg <= wack_s1_reg;
      to_s1_reg <= to_tgl_reg;
      to_s2_reg <= to_s1_reg;
    end
  end

  assign rise = scl_s2_reg & ~scl_d_reg;
  assign fall = ~scl_s2_reg & scl_d_reg;
  assign start_c = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_c = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  assign timeout_c = (to_s2_reg != to_seen_reg);
  assign wr_free = (wack_s2_reg == wr_req_reg);
  assign ptr_next = ptr_reg + 8'h01;

  // ----------------------------------------
  // Read data return from system side
  // ----------------------------------------
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      fack_seen_reg <= 1'b0;
      fetch_data_reg <= 8'h00;
      to_seen_reg <= 1'b0;
    end else begin
      to_seen_reg <= to_s2_reg;
      if (fack_s2_reg != fack_seen_reg) begin
        fack_seen_reg <= fack_s2_reg;
        fetch_data_reg <= rdata_reg;
      end
    end
  end

  // ----------------------------------------
  // Protocol engine; the clock line is only ever read
  // ----------------------------------------
  always_ff @(posedge link_clk_i or negedge lrst_n) begin
    if (!lrst_n) begin
      state_reg <= RIS_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= `RIS_PTR_RST;
      fetch_addr_reg <= `RIS_PTR_RST;
      fetch_req_reg <= 1'b0;
      first_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      snap_tgl_reg <= 1'b0;
      wr_req_reg <= 1'b0;
      wr_hold_reg <= '0;
    end else if (timeout_c) begin
      state_reg <= RIS_IDLE;
      oe_n_reg <= 1'b1;
    end else if (start_c) begin
      state_reg <= RIS_ADDR;
      cnt_reg <= 4'h0;
      oe_n_reg <= 1'b1;
      snap_tgl_reg <= ~snap_tgl_reg;
    end else if (stop_c) begin
      state_reg <= RIS_IDLE;
      oe_n_reg <= 1'b1;
      snap_tgl_reg <= ~snap_tgl_reg;
    end else begin
      unique case (state_reg)
        RIS_IDLE, RIS_IGNORE: begin
          oe_n_reg <= 1'b1;
        end
        RIS_ADDR: begin
          if (rise) begin
            sh_reg <= {sh_reg[6:0], sda_s2_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (fall && cnt_reg == `RIS_BYTE_BITS) begin
            if (sh_reg[7:1] == `RIS_DEV_ADDR) begin
              oe_n_reg <= 1'b0;
              state_reg <= RIS_ADDR_ACK;
              if (sh_reg[0]) begin
                fetch_addr_reg <= ptr_reg;
                fetch_req_reg <= ~fetch_req_reg;
              end
            end else begin
              state_reg <= RIS_IGNORE;
            end
          end
        end
        RIS_ADDR_ACK: begin
          if (fall) begin
            if (sh_reg[0]) begin
              oe_n_reg <= fetch_data_reg[7];
              tx_reg <= {fetch_data_reg[6:0], 1'b0};
              cnt_reg <= 4'h1;
              state_reg <= RIS_TX;
            end else begin
              oe_n_reg <= 1'b1;
              cnt_reg <= 4'h0;
              first_reg <= 1'b1;
              state_reg <= RIS_RX;
            end
          end
        end
        RIS_RX: begin
          if (rise) begin
            sh_reg <= {sh_reg[6:0], sda_s2_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (fall && cnt_reg == `RIS_BYTE_BITS) begin
            state_reg <= RIS_RX_ACK;
            if (first_reg) begin
              ptr_reg <= sh_reg;
              first_reg <= 1'b0;
              oe_n_reg <= 1'b0;
            end else if (wr_free) begin
              wr_hold_reg <= '{addr: ptr_reg, data: sh_reg};
              wr_req_reg <= ~wr_req_reg;
              ptr_reg <= ptr_next;
              oe_n_reg <= 1'b0;
              if (ptr_next == 8'h00) begin
                snap_tgl_reg <= ~snap_tgl_reg;
              end
            end
          end
        end
        RIS_RX_ACK: begin
          if (fall) begin
            oe_n_reg <= 1'b1;
            cnt_reg <= 4'h0;
            state_reg <= RIS_RX;
          end
        end
        RIS_TX: begin
          if (fall) begin
            if (cnt_reg == `RIS_BYTE_BITS) begin
              oe_n_reg <= 1'b1;
              state_reg <= RIS_TX_ACK;
              ptr_reg <= ptr_next;
              fetch_addr_reg <= ptr_next;
              fetch_req_reg <= ~fetch_req_reg;
              if (ptr_next == 8'h00) begin
                snap_tgl_reg <= ~snap_tgl_reg;
              end
            end else begin
              oe_n_reg <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        RIS_TX_ACK: begin
          if (rise && sda_s2_reg) begin
            state_reg <= RIS_IGNORE;
          end else if (fall) begin
            oe_n_reg <= fetch_data_reg[7];
            tx_reg <= {fetch_data_reg[6:0], 1'b0};
            cnt_reg <= 4'h1;
            state_reg <= RIS_TX;
          end
        end
      endcase
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n_o = oe_n_reg;

  // ----------------------------------------
  // System side synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      freq_s1_reg <= 1'b0;
      freq_s2_reg <= 1'b0;
      wreq_s1_reg <= 1'b0;
      wreq_s2_reg <= 1'b0;
      snp_s1_reg <= 1'b0;
      snp_s2_reg <= 1'b0;
      rscl_s1_reg <= 1'b1;
      rscl_s2_reg <= 1'b1;
    end else begin
      freq_s1_reg <= fetch_req_reg;
      freq_s2_reg <= freq_s1_reg;
      wreq_s1_reg <= wr_req_reg;
      wreq_s2_reg <= wreq_s1_reg;
      snp_s1_reg <= snap_tgl_reg;
      snp_s2_reg <= snp_s1_reg;
      rscl_s1_reg <= scl_i;
      rscl_s2_reg <= rscl_s1_reg;
    end
  end

  // ----------------------------------------
  // Clock-low timeout
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_cnt_reg <= '0;
      to_tgl_reg <= 1'b0;
    end else if (rscl_s2_reg) begin
      to_cnt_reg <= '0;
    end else if (to_cnt_reg != `RIS_TO_CNT_W'(TIMEOUT_CYC)) begin
      to_cnt_reg <= to_cnt_reg + `RIS_TO_CNT_W'(1);
      if (to_cnt_reg == `RIS_TO_CNT_W'(TIMEOUT_CYC - 1)) begin
        to_tgl_reg <= ~to_tgl_reg;
      end
    end
  end

  // ----------------------------------------
  // Register read fetch and shadow refresh
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fack_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      rd_addr_reg <= 8'h00;
      rdata_reg <= 8'h00;
      snp_seen_reg <= 1'b0;
      snap_reg <= 1'b0;
    end else begin
      if (rd_stb_reg) begin
        rdata_reg <= rd_data_i;
        fack_reg <= ~fack_reg;
        rd_stb_reg <= 1'b0;
      end else if (freq_s2_reg != fack_reg) begin
        rd_addr_reg <= fetch_addr_reg;
        rd_stb_reg <= 1'b1;
      end
      snp_seen_reg <= snp_s2_reg;
      snap_reg <= (snp_s2_reg != snp_seen_reg);
    end
  end

  assign rd_stb_o = rd_stb_reg;
  assign rd_addr_o = rd_addr_reg;
  assign snap_o = snap_reg;

  // ----------------------------------------
  // Write words into the buffer
  // ----------------------------------------
  assign fifo_push = (wreq_s2_reg != wack_reg);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wack_reg <= 1'b0;
    end else if (fifo_push && fifo_in_ready) begin
      wack_reg <= ~wack_reg;
    end
  end

  ris_fifo #(
    .WIDTH($bits(ris_word_s)),
    .DEPTH(2)
  ) u_wr_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wr_hold_reg),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_word_o)
  );
endmodule

// ### testbench/ris_i2c_slave_properties.sv
// Port assertions of the serial register-access slave
`timescale 1ns/1ps
module ris_i2c_slave_props #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire ris_pkg::ris_word_s wr_word_o,
  input wire logic rd_stb_o,
  input wire logic snap_o
);
  import ris_pkg::*;
  // ----
  // Clock low counter
  // ----
  int lo_cnt;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lo_cnt <= 0;
    else if (scl_i) lo_cnt <= 0;
    else lo_cnt <= lo_cnt + 1;
  end
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  property p_od_low;
    @(posedge link_clk_i) disable iff (!rst_n_i) !sda_oe_n_o |-> !sda_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("data pin driven high");
  property p_oe_scl_low;
    @(posedge link_clk_i) disable iff (!rst_n_i) $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved in clock high");
  property p_rd_stb;
    @(posedge ref_clk_i) disable iff (!rst_n_i) rd_stb_o |=> !rd_stb_o;
  endproperty
  a_rd_stb: assert property (p_rd_stb) else $error("fetch strobe too long");
  property p_snap;
    @(posedge ref_clk_i) disable iff (!rst_n_i) snap_o |=> !snap_o;
  endproperty
  a_snap: assert property (p_snap) else $error("refresh pulse too long");
  property p_wr_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word lost");
  property p_start_snap;
    @(posedge ref_clk_i) disable iff (!rst_n_i) s_start |-> ##[1:20] snap_o;
  endproperty
  a_start_snap: assert property (p_start_snap) else $error("no refresh on start");
  property p_stop_snap;
    @(posedge ref_clk_i) disable iff (!rst_n_i) s_stop |-> ##[1:20] snap_o;
  endproperty
  a_stop_snap: assert property (p_stop_snap) else $error("no refresh on stop");
  property p_timeout;
    @(posedge ref_clk_i) disable iff (!rst_n_i) lo_cnt > TIMEOUT_CYC + 10 |-> sda_oe_n_o;
  endproperty
  a_timeout: assert property (p_timeout) else $error("data held after timeout");
endmodule
bind ris_i2c_slave ris_i2c_slave_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) ris_i2c_slave_props_i (
  .ref_clk_i, .rst_n_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o,
  .wr_valid_o, .wr_ready_i, .wr_word_o, .rd_stb_o, .snap_o);

// ### testbench/ris_i2c_master.sv
// Bus master model making clock, start and stop
`timescale 1ns/1ps
module ris_i2c_master #(
  parameter int Q = 20
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic qw;
    repeat (Q) @(posedge clk_i);
  endtask
  task automatic bit_io(input logic b, output logic r);
    qw();
    sda_o <= b;
    qw();
    scl_o <= 1'b1;
    qw();
    r = sda_i;
    qw();
    scl_o <= 1'b0;
  endtask
  task automatic start;
    qw();
    sda_o <= 1'b1;
    qw();
    scl_o <= 1'b1;
    qw();
    sda_o <= 1'b0;
    qw();
    scl_o <= 1'b0;
  endtask
  task automatic stop;
    qw();
    sda_o <= 1'b0;
    qw();
    scl_o <= 1'b1;
    qw();
    sda_o <= 1'b1;
    qw();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule

// ### testbench/test_ris_i2c_slave.sv
// Self-checking bench of the serial register-access slave
`timescale 1ns/1ps
module test_ris_i2c_slave;
  import ris_pkg::*;
  localparam int TO_CYC = 200;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_ready = 1'b1;
  logic scl, m_sda, sda, sda_o, sda_oe_n, wr_valid, rd_stb, snap, ack;
  logic [7:0] rd_addr, d;
  logic [7:0] mem [256];
  ris_word_s wr_word;
  ris_word_s got [$];
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  always #3 link_clk = ~link_clk;
  assign sda = m_sda & (sda_oe_n | sda_o);
  ris_i2c_slave #(.TIMEOUT_CYC(TO_CYC)) ris_i2c_slave_i (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .link_clk_i(link_clk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready), .wr_word_o(wr_word), .rd_stb_o(rd_stb),
    .rd_addr_o(rd_addr), .rd_data_i(mem[rd_addr]), .snap_o(snap));
  ris_i2c_master ris_i2c_master_i (.clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  // ----
  // Register store and watchdog
  // ----
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 50000) begin
      failures++;
      results();
    end
  end
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      got.push_back(wr_word);
      mem[wr_word.addr] <= wr_word.data;
    end
  end
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    ris_i2c_master_i.put_byte(b, ack);
    check(16'(ack), 16'(exp_ack));
  endtask
  task automatic recv(input logic nack, input logic [7:0] exp);
    ris_i2c_master_i.get_byte(nack, d);
    check(16'(d), 16'(exp));
  endtask
  task automatic t_write_wrap;
    ris_i2c_master_i.start();
    send(8'hD0, 1'b1);
    send(8'hFE, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    ris_i2c_master_i.stop();
    check(got.pop_front(), 16'hFE11);
    check(got.pop_front(), 16'hFF22);
    ris_i2c_master_i.start();
    send(8'hD1, 1'b1);
    recv(1'b0, 8'hFF);
    recv(1'b1, 8'hFE);
    ris_i2c_master_i.get_byte(1'b1, d);
    check(16'(d), 16'h00FF);
    ris_i2c_master_i.stop();
  endtask
  task automatic t_ptr_read;
    ris_i2c_master_i.start();
    send(8'hD0, 1'b1);
    send(8'h10, 1'b1);
    send(8'h5A, 1'b1);
    ris_i2c_master_i.stop();
    check(got.pop_front(), 16'h105A);
    ris_i2c_master_i.start();
    send(8'hD0, 1'b1);
    send(8'h10, 1'b1);
    ris_i2c_master_i.start();
    send(8'hD1, 1'b1);
    recv(1'b0, 8'h5A);
    recv(1'b1, 8'hEE);
    ris_i2c_master_i.stop();
  endtask
  task automatic t_stall;
    @(posedge ref_clk) wr_ready <= 1'b0;
    ris_i2c_master_i.start();
    send(8'hD0, 1'b1);
    send(8'h20, 1'b1);
    send(8'h01, 1'b1);
    send(8'h02, 1'b1);
    send(8'h03, 1'b1);
    send(8'h04, 1'b0);
    ris_i2c_master_i.stop();
    check(16'(wr_valid), 16'h0001);
    @(posedge ref_clk) wr_ready <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check(got.pop_front(), 16'h2001);
    check(got.pop_front(), 16'h2102);
    check(got.pop_front(), 16'h2203);
    check(16'(got.size()), 16'h0000);
    ris_i2c_master_i.start();
    send(8'hD1, 1'b1);
    recv(1'b1, 8'hDC);
    ris_i2c_master_i.stop();
  endtask
  task automatic t_bad_addr;
    ris_i2c_master_i.start();
    send(8'hA0, 1'b0);
    send(8'hD0, 1'b0);
    ris_i2c_master_i.stop();
  endtask
  task automatic t_timeout;
    logic [7:0] a;
    a = 8'hD0;
    ris_i2c_master_i.start();
    for (int i = 7; i >= 0; i--) ris_i2c_master_i.bit_io(a[i], ack);
    repeat (10) @(posedge ref_clk);
    check(16'(sda_oe_n), 16'h0000);
    repeat (TO_CYC + 50) @(posedge ref_clk);
    check(16'(sda_oe_n), 16'h0001);
    ris_i2c_master_i.bit_io(1'b1, ack);
    ris_i2c_master_i.stop();
    ris_i2c_master_i.start();
    send(8'hD0, 1'b1);
    ris_i2c_master_i.stop();
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_write_wrap();
    t_ptr_read();
    t_stall();
    t_bad_addr();
    t_timeout();
    results();
  end
endmodule
